// File: rtl/txmod_pkg.sv
// Package: register map, field layout, reset values and constants of the modulation block
package txmod_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MOD_CTRL2    = 8'h71;
  localparam logic [7:0] IDX_DEV_LOW      = 8'h72;
  localparam logic [7:0] IDX_OFS_LOW      = 8'h73;
  localparam logic [7:0] IDX_OFS_HIGH     = 8'h74;
  localparam logic [7:0] IDX_BAND_SEL     = 8'h75;
  localparam logic [7:0] IDX_CARRIER_HIGH = 8'h76;
  localparam logic [7:0] IDX_CARRIER_LOW  = 8'h77;
  localparam logic [7:0] IDX_HOP_CHANNEL  = 8'h79;
  localparam logic [7:0] IDX_HOP_STEP     = 8'h7a;
  localparam logic [7:0] IDX_TX_STATUS    = 8'h60;
  localparam logic [7:0] IDX_CARRIER_RB0  = 8'h61;
  localparam logic [7:0] IDX_CARRIER_RB1  = 8'h62;
  localparam logic [7:0] IDX_CARRIER_RB2  = 8'h63;

  // Reset values
  localparam logic [7:0] RST_MOD_CTRL2    = 8'h00;
  localparam logic [7:0] RST_DEV_LOW      = 8'h20;
  localparam logic [7:0] RST_OFS_LOW      = 8'h00;
  localparam logic [7:0] RST_OFS_HIGH     = 8'h00;
  localparam logic [7:0] RST_BAND_SEL     = 8'h75;
  localparam logic [7:0] RST_CARRIER_HIGH = 8'hbb;
  localparam logic [7:0] RST_CARRIER_LOW  = 8'h80;
  localparam logic [7:0] RST_HOP          = 8'h00;

  // Field positions in modulation control two
  localparam int unsigned ROUTE_LSB   = 6;
  localparam int unsigned SOURCE_LSB  = 4;
  localparam int unsigned INVERT_BIT  = 3;
  localparam int unsigned DEV_MSB_BIT = 2;
  localparam int unsigned TYPE_LSB    = 0;

  // Field positions in band select; offset high keeps only its low two bits
  localparam int unsigned SIDEBAND_BIT = 6;
  localparam int unsigned HIGHBAND_BIT = 5;
  localparam logic [7:0]  BAND_WMASK   = 8'h7f;
  localparam logic [7:0]  OFS_HI_WMASK = 8'h03;

  typedef enum logic [1:0] {
    ROUTE_NONE = 2'b00,
    ROUTE_GPIO = 2'b01,
    ROUTE_SDO  = 2'b10,
    ROUTE_IRQ  = 2'b11
  } clk_route_e;

  typedef enum logic [1:0] {
    SRC_GPIO = 2'b00,
    SRC_SDI  = 2'b01,
    SRC_FIFO = 2'b10,
    SRC_PN9  = 2'b11
  } mod_source_e;

  typedef enum logic [1:0] {
    MOD_CARRIER = 2'b00,
    MOD_OOK     = 2'b01,
    MOD_FSK     = 2'b10,
    MOD_GFSK    = 2'b11
  } mod_type_e;

  // Frequency arithmetic constants
  localparam int unsigned DEV_STEP_HZ      = 625;
  localparam int unsigned OFS_STEP_QHZ     = 625;   // 156.25 Hz in quarter hertz
  localparam int unsigned BAND_BASE        = 24;
  localparam int unsigned BAND_KHZ         = 10000;
  localparam int unsigned FRAC_DEN         = 64000;
  localparam int unsigned FRAC_NUM_SCALED  = 5;     // BAND_KHZ / FRAC_DEN = 5 / 32
  localparam int unsigned FRAC_SHIFT       = 5;
  localparam int unsigned HOP_STEP_KHZ     = 10;
  localparam logic [8:0]  PN9_SEED         = 9'h1ff;

endpackage : txmod_pkg

// File: rtl/pin_sync.sv
// Two-stage synchronisers with rising edge detection for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned N = 4
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
        end else begin
          stage1 <= pin_in[i];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end
      // Edge taken between second and third stage, never from the first
      assign level[i] = stage2;
      assign rise[i]  = stage2 & ~stage3;
    end
  endgenerate

endmodule : pin_sync

// File: rtl/freq_calc.sv
// Registered deviation, offset and carrier arithmetic from the frozen settings
`timescale 1ns/1ps
module freq_calc (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [8:0]  freq_deviation_word,
  input  wire logic [9:0]  freq_offset_word,
  input  wire logic        high_band_select,
  input  wire logic [4:0]  band_index,
  input  wire logic [15:0] carrier_fraction_word,
  input  wire logic [7:0]  hop_channel,
  input  wire logic [7:0]  hop_step,
  output logic      [19:0] deviation_hz,
  output logic      [21:0] offset_qhz,
  output logic      [23:0] carrier_khz
);

  logic        [1:0]  band_mult;
  logic signed [17:0] frac_sum;
  logic signed [23:0] frac_khz;
  logic        [23:0] base_khz;
  logic        [23:0] hop_khz;

  assign band_mult = {1'b0, high_band_select} + 2'd1;
  assign frac_sum  = $signed({2'b00, carrier_fraction_word})
                   + $signed({{8{freq_offset_word[9]}}, freq_offset_word});
  // (fc + fo) * 10000 / 64000 reduced to * 5 / 32, scaled by the band before the shift by 5
  assign frac_khz  = 24'(($signed({{6{frac_sum[17]}}, frac_sum})
                   * $signed(24'(txmod_pkg::FRAC_NUM_SCALED))
                   * $signed({22'd0, band_mult})) >>> txmod_pkg::FRAC_SHIFT);
  assign base_khz  = 24'(({19'd0, band_index} + 24'(txmod_pkg::BAND_BASE))
                   * 24'(txmod_pkg::BAND_KHZ) * {22'd0, band_mult});
  assign hop_khz   = 24'({16'd0, hop_channel} * {16'd0, hop_step}
                   * 24'(txmod_pkg::HOP_STEP_KHZ));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      deviation_hz <= 20'h00000;
      offset_qhz   <= 22'h000000;
      carrier_khz  <= 24'h000000;
    end else begin
      deviation_hz <= 20'({11'd0, freq_deviation_word} * 20'(txmod_pkg::DEV_STEP_HZ));
      offset_qhz   <= 22'($signed({{12{freq_offset_word[9]}}, freq_offset_word})
                    * $signed(22'(txmod_pkg::OFS_STEP_QHZ))
                    * $signed({20'd0, band_mult}));
      carrier_khz  <= base_khz + frac_khz + hop_khz;
    end
  end

endmodule : freq_calc

// File: rtl/tx_mod_config.sv
// Transmit modulation and frequency configuration block with register slave
//
// How it works
// - Clock route 00 drives no data clock; direct GFSK then falls back to FSK.
// - Clock route 01 sends data clock to GPIO, 10 to SDO, 11 to interrupt pin.
// - Source 00 takes direct data from a GPIO; host assigns that GPIO function.
// - Source 01 takes SDI only while select is high; 10 FIFO; 11 PN9.
// - Type 00 carrier, 01 OOK, 10 FSK, 11 GFSK.
// - Nine-bit deviation: MSB at control bit 2, low byte in deviation register.
// - Deviation equals 625 Hz times the deviation word.
// - Offset equals 156.25 Hz times (high band plus one) times offset word.
// - Offset word is ten-bit two's complement split over two registers.
// - High band bit selects 480-930 MHz, clear selects 240-479.9 MHz.
// - Each band step is 10 MHz low range, 20 MHz high range.
// - Band 0 starts at 240 or 480 MHz, band 1 at 250 or 500 MHz.
// - Carrier in kHz follows the band, fraction, offset and hopping formula.
// - Sixteen-bit fraction word: upper byte first register, lower byte next.
// - Reset values 0x75 band, 0xbb and 0x80 carrier, 0x20 deviation.
// - Offset high bits 7:2 are read-only zero; only bits 1:0 are writable.
// - Hop step in 10 kHz units times hop channel forms the hopping term.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module tx_mod_config (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Asynchronous pins
  input  wire logic        data_clk,
  input  wire logic        gpio_tx_data,
  input  wire logic        sdi,
  input  wire logic        serial_select_n,
  // Core side, same clock
  input  wire logic        tx_request,
  input  wire logic        fifo_bit,
  input  wire logic        fifo_bit_valid,
  output logic             fifo_bit_take,
  // Modulator and synthesiser side
  output logic             tx_active,
  output logic             mod_data,
  output logic             mod_data_strobe,
  output logic [1:0]       mod_type,
  output logic             high_band_select,
  output logic             sideband_select,
  output logic [4:0]       band_index,
  output logic [19:0]      deviation_hz,
  output logic [21:0]      offset_qhz,
  output logic [23:0]      carrier_khz,
  // Data clock outputs, one per route
  output logic             gpio_clk_out,
  output logic             sdo_clk_out,
  output logic             irq_out_n
);

  // Software-visible registers
  logic [7:0] modulation_control_two;
  logic [7:0] deviation_low;
  logic [7:0] offset_low;
  logic [7:0] offset_high;
  logic [7:0] band_select;
  logic [7:0] carrier_high;
  logic [7:0] carrier_low;
  logic [7:0] hop_channel;
  logic [7:0] hop_step;

  // Frozen copies used while transmitting
  logic [7:0] act_ctrl;
  logic [8:0] act_dev;
  logic [9:0] act_ofs;
  logic [7:0] act_band;
  logic [15:0] act_frac;
  logic [7:0] act_hch;
  logic [7:0] act_hstep;

  // Bus decode
  logic       access;
  logic       word_ok;
  logic [7:0] index;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] next_rbyte;
  logic       pending;
  logic       gfsk_fallback;

  assign access  = read | write;
  assign index   = address[9:2];
  assign word_ok = (address[1:0] == 2'b00);
  assign wbyte   = writedata[7:0];
  // Write commits only at the edge where the master sees waitrequest low
  assign wr_en   = write & ~waitrequest & word_ok;

  // One wait state: request seen, then waitrequest drops for one cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if (access && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_rbyte = 8'h00;
    if (word_ok) begin
      unique case (index)
        txmod_pkg::IDX_MOD_CTRL2:    next_rbyte = modulation_control_two;
        txmod_pkg::IDX_DEV_LOW:      next_rbyte = deviation_low;
        txmod_pkg::IDX_OFS_LOW:      next_rbyte = offset_low;
        txmod_pkg::IDX_OFS_HIGH:     next_rbyte = offset_high;
        txmod_pkg::IDX_BAND_SEL:     next_rbyte = band_select;
        txmod_pkg::IDX_CARRIER_HIGH: next_rbyte = carrier_high;
        txmod_pkg::IDX_CARRIER_LOW:  next_rbyte = carrier_low;
        txmod_pkg::IDX_HOP_CHANNEL:  next_rbyte = hop_channel;
        txmod_pkg::IDX_HOP_STEP:     next_rbyte = hop_step;
        txmod_pkg::IDX_TX_STATUS:    next_rbyte = {5'd0, gfsk_fallback, pending, tx_active};
        txmod_pkg::IDX_CARRIER_RB0:  next_rbyte = carrier_khz[7:0];
        txmod_pkg::IDX_CARRIER_RB1:  next_rbyte = carrier_khz[15:8];
        txmod_pkg::IDX_CARRIER_RB2:  next_rbyte = carrier_khz[23:16];
        default:                     next_rbyte = 8'h00;
      endcase
    end
  end

  // Read data is loaded as waitrequest drops and holds until the next read
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= {24'h000000, next_rbyte};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      modulation_control_two <= txmod_pkg::RST_MOD_CTRL2;
      deviation_low          <= txmod_pkg::RST_DEV_LOW;
      offset_low             <= txmod_pkg::RST_OFS_LOW;
      offset_high            <= txmod_pkg::RST_OFS_HIGH;
      band_select            <= txmod_pkg::RST_BAND_SEL;
      carrier_high           <= txmod_pkg::RST_CARRIER_HIGH;
      carrier_low            <= txmod_pkg::RST_CARRIER_LOW;
      hop_channel            <= txmod_pkg::RST_HOP;
      hop_step               <= txmod_pkg::RST_HOP;
    end else if (wr_en) begin
      unique case (index)
        txmod_pkg::IDX_MOD_CTRL2:    modulation_control_two <= wbyte;
        txmod_pkg::IDX_DEV_LOW:      deviation_low <= wbyte;
        txmod_pkg::IDX_OFS_LOW:      offset_low <= wbyte;
        txmod_pkg::IDX_OFS_HIGH:     offset_high <= wbyte & txmod_pkg::OFS_HI_WMASK;
        txmod_pkg::IDX_BAND_SEL:     band_select <= wbyte & txmod_pkg::BAND_WMASK;
        txmod_pkg::IDX_CARRIER_HIGH: carrier_high <= wbyte;
        txmod_pkg::IDX_CARRIER_LOW:  carrier_low <= wbyte;
        txmod_pkg::IDX_HOP_CHANNEL:  hop_channel <= wbyte;
        txmod_pkg::IDX_HOP_STEP:     hop_step <= wbyte;
        default:                     hop_step <= hop_step;
      endcase
    end
  end

  // Transmission framing: a request starts a frame, its release ends it
  logic start;

  // Pending flags that software has written a register during a frame
  assign start = tx_request & ~tx_active;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_active <= 1'b0;
    end else begin
      tx_active <= tx_request;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else if (tx_active && wr_en) begin
      pending <= 1'b1;
    end else if (start) begin
      pending <= 1'b0;
    end
  end

  // Live values track the registers outside a frame and freeze inside it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      act_ctrl  <= txmod_pkg::RST_MOD_CTRL2;
      act_dev   <= {1'b0, txmod_pkg::RST_DEV_LOW};
      act_ofs   <= {txmod_pkg::RST_OFS_HIGH[1:0], txmod_pkg::RST_OFS_LOW};
      act_band  <= txmod_pkg::RST_BAND_SEL;
      act_frac  <= {txmod_pkg::RST_CARRIER_HIGH, txmod_pkg::RST_CARRIER_LOW};
      act_hch   <= txmod_pkg::RST_HOP;
      act_hstep <= txmod_pkg::RST_HOP;
    end else if (!tx_active) begin
      act_ctrl  <= modulation_control_two;
      act_dev   <= {modulation_control_two[txmod_pkg::DEV_MSB_BIT], deviation_low};
      act_ofs   <= {offset_high[1:0], offset_low};
      act_band  <= band_select;
      act_frac  <= {carrier_high, carrier_low};
      act_hch   <= hop_channel;
      act_hstep <= hop_step;
    end
  end

  // Decoded fields of the frozen control
  logic [1:0] route;
  logic [1:0] source;
  logic [1:0] type_req;
  logic       invert;
  logic       direct_src;

  assign route      = act_ctrl[txmod_pkg::ROUTE_LSB +: 2];
  assign source     = act_ctrl[txmod_pkg::SOURCE_LSB +: 2];
  assign type_req   = act_ctrl[txmod_pkg::TYPE_LSB +: 2];
  assign invert     = act_ctrl[txmod_pkg::INVERT_BIT];
  assign direct_src = (source == txmod_pkg::SRC_GPIO) || (source == txmod_pkg::SRC_SDI);
  // Without a data clock direct GFSK cannot be timed by the host
  assign gfsk_fallback = direct_src && (route == txmod_pkg::ROUTE_NONE)
                       && (type_req == txmod_pkg::MOD_GFSK);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mod_type         <= txmod_pkg::MOD_CARRIER;
      high_band_select <= 1'b0;
      sideband_select  <= 1'b0;
      band_index       <= 5'd0;
    end else begin
      mod_type         <= gfsk_fallback ? txmod_pkg::MOD_FSK : type_req;
      high_band_select <= act_band[txmod_pkg::HIGHBAND_BIT];
      sideband_select  <= act_band[txmod_pkg::SIDEBAND_BIT];
      band_index       <= act_band[4:0];
    end
  end

  // Pin synchronisers: data clock, GPIO data, SDI, select
  logic [3:0] pin_level;
  logic [3:0] pin_rise;

  pin_sync #(.N(4)) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in ({serial_select_n, sdi, gpio_tx_data, data_clk}),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  logic clk_level;
  logic bit_tick;

  assign clk_level = pin_level[0];
  assign bit_tick  = pin_rise[0] & tx_active;

  // Data clock goes to at most one pin; interrupt pin idles high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gpio_clk_out <= 1'b0;
      sdo_clk_out  <= 1'b0;
      irq_out_n    <= 1'b1;
    end else begin
      gpio_clk_out <= tx_active && (route == txmod_pkg::ROUTE_GPIO) && clk_level;
      sdo_clk_out  <= tx_active && (route == txmod_pkg::ROUTE_SDO) && clk_level;
      irq_out_n    <= !(tx_active && (route == txmod_pkg::ROUTE_IRQ) && clk_level);
    end
  end

  // PN9 generator, x^9 + x^5 + 1, restarted at each frame start
  logic [8:0] pn9;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pn9 <= txmod_pkg::PN9_SEED;
    end else if (start) begin
      pn9 <= txmod_pkg::PN9_SEED;
    end else if (bit_tick && source == txmod_pkg::SRC_PN9) begin
      pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]};
    end
  end

  // Source selection for the next data bit
  logic raw_bit;
  logic bit_ok;

  always_comb begin
    raw_bit = 1'b0;
    bit_ok  = 1'b0;
    unique case (source)
      txmod_pkg::SRC_GPIO: begin
        raw_bit = pin_level[1];
        bit_ok  = 1'b1;
      end
      txmod_pkg::SRC_SDI: begin
        raw_bit = pin_level[2];
        bit_ok  = pin_level[3];
      end
      txmod_pkg::SRC_FIFO: begin
        raw_bit = fifo_bit;
        bit_ok  = fifo_bit_valid;
      end
      txmod_pkg::SRC_PN9: begin
        raw_bit = pn9[8];
        bit_ok  = 1'b1;
      end
    endcase
  end

  // A bit is taken on each data clock rise within a frame; a missing bit leaves the last one
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mod_data        <= 1'b0;
      mod_data_strobe <= 1'b0;
      fifo_bit_take   <= 1'b0;
    end else begin
      mod_data_strobe <= bit_tick && bit_ok;
      fifo_bit_take   <= bit_tick && bit_ok && (source == txmod_pkg::SRC_FIFO);
      if (bit_tick && bit_ok) begin
        mod_data <= raw_bit ^ invert;
      end
    end
  end

  freq_calc u_freq_calc (
    .mclk                  (mclk),
    .resetn                (resetn),
    .freq_deviation_word   (act_dev),
    .freq_offset_word      (act_ofs),
    .high_band_select      (act_band[txmod_pkg::HIGHBAND_BIT]),
    .band_index            (act_band[4:0]),
    .carrier_fraction_word (act_frac),
    .hop_channel           (act_hch),
    .hop_step              (act_hstep),
    .deviation_hz          (deviation_hz),
    .offset_qhz            (offset_qhz),
    .carrier_khz           (carrier_khz)
  );

endmodule : tx_mod_config

// File: dv/tx_mod_config_assertions.sv
// Assertion checker on the block's ports, with its bind
`timescale 1ns/1ps
module tx_mod_config_assertions (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        data_clk,
  input wire logic        tx_request,
  input wire logic        tx_active,
  input wire logic        mod_data_strobe,
  input wire logic [1:0]  mod_type,
  input wire logic [4:0]  band_index,
  input wire logic [19:0] deviation_hz,
  input wire logic [21:0] offset_qhz,
  input wire logic        gpio_clk_out,
  input wire logic        sdo_clk_out,
  input wire logic        irq_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest ##1 waitrequest; endsequence
  property p_bus_answer; s_req |=> s_ans; endproperty
  property p_upper_zero; readdata[31:8] == 24'h0; endproperty
  property p_frame; $past(resetn) |-> tx_active == $past(tx_request); endproperty
  property p_idle_clk; !tx_active && !$past(tx_active)
    |-> !gpio_clk_out && !sdo_clk_out && irq_out_n; endproperty
  property p_gpio_clk; gpio_clk_out |-> $past(data_clk, 3); endproperty
  property p_irq_clk; !irq_out_n |-> $past(data_clk, 3); endproperty
  property p_one_route; $onehot0({gpio_clk_out, sdo_clk_out, !irq_out_n}); endproperty
  property p_dev_step; deviation_hz % 625 == 0; endproperty
  property p_ofs_step; $signed(offset_qhz) % 625 == 0; endproperty
  property p_strobe; mod_data_strobe |=> !mod_data_strobe; endproperty
  property p_frozen; tx_active && $past(tx_active) && $past(tx_active, 2)
    |-> $stable(mod_type) && $stable(band_index); endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not after one wait state");
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
  a_frame: assert property (p_frame)
    else $error("frame flag does not follow request");
  a_idle_clk: assert property (p_idle_clk)
    else $error("data clock output outside a frame");
  a_gpio_clk: assert property (p_gpio_clk)
    else $error("gpio clock high without link clock");
  a_irq_clk: assert property (p_irq_clk)
    else $error("interrupt pin clock low without link clock");
  a_one_route: assert property (p_one_route)
    else $error("data clock on more than one pin");
  a_dev_step: assert property (p_dev_step)
    else $error("deviation not a multiple of the step");
  a_ofs_step: assert property (p_ofs_step)
    else $error("offset not a multiple of the step");
  a_strobe: assert property (p_strobe)
    else $error("data strobe longer than one cycle");
  a_frozen: assert property (p_frozen)
    else $error("settings changed within a frame");
endmodule : tx_mod_config_assertions

bind tx_mod_config tx_mod_config_assertions tx_mod_config_assertions_i (
  .mclk(mclk), .resetn(resetn), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .data_clk(data_clk), .tx_request(tx_request),
  .tx_active(tx_active), .mod_data_strobe(mod_data_strobe), .mod_type(mod_type),
  .band_index(band_index), .deviation_hz(deviation_hz), .offset_qhz(offset_qhz),
  .gpio_clk_out(gpio_clk_out), .sdo_clk_out(sdo_clk_out), .irq_out_n(irq_out_n));

// File: dv/host_link.sv
// Host-side model: link bit clock and direct data pins
`timescale 1ns/1ps
module host_link (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic       sel_n,
  input  wire logic [7:0] pattern,
  output logic            data_clk,
  output logic            gpio_tx_data,
  output logic            sdi,
  output logic            serial_select_n
);
  int k;
  initial begin
    data_clk = 1'b0;
    gpio_tx_data = 1'b0;
    sdi = 1'b1;
    k = 0;
  end
  assign serial_select_n = sel_n;
  always begin
    if (run) begin
      gpio_tx_data = pattern[k % 8];
      sdi = pattern[k % 8];
      #62.5 data_clk = 1'b1;
      #62.5 data_clk = 1'b0;
      k++;
    end else begin
      @(posedge mclk);
      // Clock stands still; data lines wander so stray sampling shows
      k = 0;
      gpio_tx_data = ~gpio_tx_data;
      sdi = ~sdi;
    end
  end
endmodule : host_link

// File: dv/testbench.sv
// Self-checking bench for the modulation configuration block
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, tx_request = 1'b0;
  logic        fifo_bit = 1'b1, fifo_bit_valid = 1'b1, run = 1'b0, sel_n = 1'b1, inv_bit;
  logic [9:0]  address = 10'h000;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [7:0]  pattern = 8'hb2;
  logic        waitrequest, fifo_bit_take, tx_active, mod_data, mod_data_strobe;
  logic        high_band_select, sideband_select, gpio_clk_out, sdo_clk_out, irq_out_n;
  logic        data_clk, gpio_tx_data, sdi, serial_select_n;
  logic [1:0]  mod_type;
  logic [4:0]  band_index;
  logic [19:0] deviation_hz;
  logic [21:0] offset_qhz;
  logic [23:0] carrier_khz;
  int          errors = 0, n_compared = 0, mode = 0;
  int          n_strobe, n_take, n_gpio, n_sdo, n_irq;

  always #2.5 mclk = ~mclk;

  tx_mod_config tx_mod_config_i (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .data_clk(data_clk), .gpio_tx_data(gpio_tx_data), .sdi(sdi),
    .serial_select_n(serial_select_n), .tx_request(tx_request), .fifo_bit(fifo_bit),
    .fifo_bit_valid(fifo_bit_valid), .fifo_bit_take(fifo_bit_take), .tx_active(tx_active),
    .mod_data(mod_data), .mod_data_strobe(mod_data_strobe), .mod_type(mod_type),
    .high_band_select(high_band_select), .sideband_select(sideband_select),
    .band_index(band_index), .deviation_hz(deviation_hz), .offset_qhz(offset_qhz),
    .carrier_khz(carrier_khz), .gpio_clk_out(gpio_clk_out), .sdo_clk_out(sdo_clk_out),
    .irq_out_n(irq_out_n));

  host_link host_link_i (
    .mclk(mclk), .run(run), .sel_n(sel_n), .pattern(pattern), .data_clk(data_clk),
    .gpio_tx_data(gpio_tx_data), .sdi(sdi), .serial_select_n(serial_select_n));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int t;
    t = 0;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
      t++;
    end while (waitrequest !== 1'b0 && t < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
    if (t >= 50) check("bus answer", 32'h0, 32'h1);
  endtask : bus

  always @(posedge mclk) begin
    if (mod_data_strobe === 1'b1) begin
      if (mode == 1) check("pin bit", pattern[n_strobe % 8] ^ inv_bit, mod_data);
      if (mode == 2) check("fixed bit", 1'b1 ^ inv_bit, mod_data);
      n_strobe++;
    end
    n_take += (fifo_bit_take === 1'b1);
    n_gpio += (gpio_clk_out === 1'b1);
    n_sdo += (sdo_clk_out === 1'b1);
    n_irq += (irq_out_n === 1'b0);
  end

  task automatic t_reset;
    logic [7:0] rv [9] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h75, 8'hbb, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, (i < 7) ? 8'h71 + i : 8'h72 + i, 8'h00, rd);
      check("reset value", rv[i], rd);
    end
    $display("reset values done");
  endtask : t_reset

  task automatic t_masks;
    bus(1'b1, 8'h74, 8'hff, rd);
    bus(1'b0, 8'h74, 8'h00, rd);
    check("offset high", 32'h03, rd);
    bus(1'b1, 8'h75, 8'hff, rd);
    bus(1'b0, 8'h75, 8'h00, rd);
    check("band select", 32'h7f, rd);
    bus(1'b1, 8'h10, 8'h5a, rd);
    bus(1'b0, 8'h10, 8'h00, rd);
    check("unmapped", 32'h0, rd);
    $display("access masks done");
  endtask : t_masks

  task automatic t_freq(input logic [7:0] v [9]);
    int fd, fo, fc, hb, cr;
    for (int i = 0; i < 9; i++) bus(1'b1, (i < 7) ? 8'h71 + i : 8'h72 + i, v[i], rd);
    repeat (6) @(posedge mclk);
    fd = {v[0][2], v[1]};
    fo = $signed({v[3][1:0], v[2]});
    fc = {v[5], v[6]};
    hb = v[4][5];
    cr = (v[4][4:0] + 24) * 10000 * (hb + 1) + (fc + fo) * 10000 * (hb + 1) / 64000;
    check("deviation", 625 * fd, deviation_hz);
    check("offset", 625 * (hb + 1) * fo, {{10{offset_qhz[21]}}, offset_qhz});
    check("carrier", cr + v[7] * v[8] * 10, carrier_khz);
    check("band", v[4][6:0], {sideband_select, high_band_select, band_index});
    $display("frequency case done");
  endtask : t_freq

  task automatic frame(input logic [7:0] ctrl, input logic seln, input logic [1:0] ty,
                       input int n, input int kind);
    logic [4:0] old;
    bus(1'b1, 8'h71, ctrl, rd);
    sel_n <= seln;
    inv_bit = ctrl[3];
    {n_strobe, n_take, n_gpio, n_sdo, n_irq} = '0;
    tx_request <= 1'b1;
    repeat (3) @(posedge mclk);
    check("mod type", ty, mod_type);
    mode = kind;
    old = band_index;
    run = 1'b1;
    bus(1'b1, 8'h75, 8'h2a, rd);
    check("frozen band", old, band_index);
    repeat (8) @(posedge data_clk);
    run = 1'b0;
    @(negedge data_clk);
    repeat (10) @(posedge mclk);
    mode = 0;
    check("strobes", n, n_strobe);
    check("fifo takes", (ctrl[5:4] == 2'b10) ? n : 0, n_take);
    check("gpio clock", ctrl[7:6] == 2'b01, n_gpio != 0);
    check("sdo clock", ctrl[7:6] == 2'b10, n_sdo != 0);
    check("irq clock", ctrl[7:6] == 2'b11, n_irq != 0);
    tx_request <= 1'b0;
    repeat (4) @(posedge mclk);
    check("band after frame", 32'h0a, band_index);
    $display("frame %h done", ctrl);
  endtask : frame

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    errors++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_masks();
    t_freq('{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    t_freq('{8'h04, 8'hff, 8'hfd, 8'h03, 8'h21, 8'h80, 8'h00, 8'h02, 8'h05});
    t_freq('{8'h00, 8'h40, 8'hff, 8'h01, 8'h5f, 8'hbb, 8'h80, 8'hff, 8'hff});
    frame(8'h41, 1'b1, 2'b01, 8, 1);
    frame(8'h9a, 1'b1, 2'b10, 8, 1);
    frame(8'he3, 1'b1, 2'b11, 8, 2);
    frame(8'h30, 1'b1, 2'b00, 8, 2);
    frame(8'h03, 1'b1, 2'b10, 8, 1);
    frame(8'h52, 1'b0, 2'b10, 0, 0);
    wrap_up();
  end
endmodule : testbench
